/* src/frm_ctrl.sv */
// flash rewrite mode control: start-up mode, access mode, commands, protection
`timescale 1ns/1ps
module frm_ctrl
    import frm_pkg::*;
#(
    parameter int unsigned       USER_BLK_BITS = 13
)(
    input  wire logic            clock,
    input  wire logic            rst_b,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic            processor_mode_pin,
    input  wire logic            boot_select_pin,
    input  wire logic            chip_enable_pin,
    input  wire logic            serial_clock_pin,
    input  wire logic            serial_transmit_pin,
    input  wire logic            readout_protect,
    input  wire frm_pkg::frm_prog_s prog,
    output logic                 prog_busy,
    output logic                 prog_read_en,
    input  wire frm_pkg::frm_resp_s resp,
    output frm_pkg::frm_op_s     op,
    output logic                 flash_ctl_rst,
    output logic                 cpu_flash_read_en,
    output logic                 fetch_from_boot,
    output logic      [15:0]     reset_vector_addr,
    output frm_pkg::frm_start_e  start_mode,
    output frm_pkg::frm_acc_e    access_mode
);
    import frm_pkg::*;

    typedef enum logic {FRM_IDLE, FRM_BUSY} frm_state_e;

    localparam logic [ADDR_W-1:0] USER_MASK = ADDR_W'((1 << USER_BLK_BITS) - 1);
    localparam logic [ADDR_W-1:0] BOOT_MASK = ADDR_W'((1 << BOOT_BLK_BITS) - 1);

    frm_state_e                  state_r, state_nxt;
    frm_start_e                  start_r, start_nxt;
    logic                        sampled_r, sampled_nxt;
    logic                        rewrite_r, rewrite_nxt;
    logic                        wr0_seen_r, wr0_seen_nxt;
    logic                        frst_r, frst_nxt;
    logic                        perr_r, perr_nxt;
    logic                        eerr_r, eerr_nxt;
    logic [ADDR_W:0]             addr_r, addr_nxt;
    logic [DATA_W-1:0]           data_r, data_nxt;
    logic [DATA_W-1:0]           rdat_r, rdat_nxt;
    frm_op_s                     op_r, op_nxt;
    logic [31:0]                 prdata_r, prdata_nxt;
    logic                        pslverr_r, pslverr_nxt;

    logic                        setup, wr_acc, mapped;
    logic                        wr_ctrl, wr_cmd;
    logic                        par_mode, cmd_go, cmd_boot, allowed;
    logic [7:0]                  cmd_code;
    logic [ADDR_W-1:0]           cmd_addr;
    logic [DATA_W-1:0]           cmd_data;
    logic [31:0]                 ctrl_view;

    // reads are latched in setup so the answer comes from a flop
    assign setup   = psel && !penable;
    assign wr_acc  = psel && penable && pwrite;
    assign mapped  = paddr inside {OFS_CTRL, OFS_ADDR, OFS_DATA, OFS_CMD, OFS_RDAT};
    assign wr_ctrl = wr_acc && paddr == OFS_CTRL;
    assign wr_cmd  = wr_acc && paddr == OFS_CMD;
    assign pready  = 1'b1;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    always_comb
    begin
        ctrl_view                        = '0;
        ctrl_view[B_READY]               = state_r == FRM_IDLE;
        ctrl_view[B_REWRITE]             = rewrite_r;
        ctrl_view[B_FRST]                = frst_r;
        ctrl_view[B_PERR]                = perr_r;
        ctrl_view[B_EERR]                = eerr_r;
        ctrl_view[B_START_LO +: 2]       = start_r;
    end

    always_comb
    begin
        prdata_nxt  = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup)
        begin
            pslverr_nxt = !mapped;
            unique case (paddr)
                OFS_CTRL: prdata_nxt = ctrl_view;
                OFS_ADDR: prdata_nxt = 32'(addr_r);
                OFS_DATA: prdata_nxt = 32'(data_r);
                OFS_RDAT: prdata_nxt = 32'(rdat_r);
                default:  prdata_nxt = '0;
            endcase
        end
    end

    // start-up mode: pins caught once, on the first edge after release
    always_comb
    begin
        start_nxt   = start_r;
        sampled_nxt = 1'b1;
        if (!sampled_r)
        begin
            if (!processor_mode_pin)
                start_nxt = FRM_START_NORMAL;
            else if (!boot_select_pin && chip_enable_pin && !serial_clock_pin && serial_transmit_pin)
                start_nxt = FRM_START_BOOT;
            else
                start_nxt = FRM_START_PARALLEL;
        end
    end

    assign par_mode          = sampled_r && start_r == FRM_START_PARALLEL;
    assign start_mode        = start_r;
    assign fetch_from_boot   = start_r == FRM_START_BOOT;
    assign reset_vector_addr = BOOT_VECTOR;
    assign flash_ctl_rst     = frst_r;
    assign cpu_flash_read_en = !rewrite_r;
    assign op                = op_r;
    assign prog_busy         = state_r != FRM_IDLE;
    // programmer read-out only when protection is off
    assign prog_read_en      = (par_mode || access_mode == FRM_ACC_SERIAL) && !readout_protect;

    always_comb
    begin
        if (rewrite_r)
            access_mode = FRM_ACC_CPU;
        else if (par_mode)
            access_mode = FRM_ACC_PARALLEL;
        else if (start_r == FRM_START_BOOT)
            access_mode = FRM_ACC_SERIAL;
        else
            access_mode = FRM_ACC_NONE;
    end

    // command source: programmer port in parallel mode, otherwise registers in rewrite mode
    always_comb
    begin
        if (par_mode)
        begin
            cmd_go   = prog.req && state_r == FRM_IDLE;
            cmd_code = prog.cmd;
            cmd_boot = prog.boot_area;
            cmd_addr = prog.addr;
            cmd_data = prog.data;
        end
        else
        begin
            cmd_go   = wr_cmd && rewrite_r && !frst_r && state_r == FRM_IDLE;
            cmd_code = pwdata[7:0];
            cmd_boot = addr_r[B_AREA];
            cmd_addr = addr_r[ADDR_W-1:0];
            cmd_data = data_r;
        end
    end

    // boot area writable only from the parallel programmer
    assign allowed = !cmd_boot || par_mode;

    always_comb
    begin
        rewrite_nxt  = rewrite_r;
        wr0_seen_nxt = wr0_seen_r;
        frst_nxt     = frst_r;
        addr_nxt     = addr_r;
        data_nxt     = data_r;
        if (wr_ctrl)
        begin
            wr0_seen_nxt = !pwdata[B_REWRITE];
            if (!pwdata[B_REWRITE])
                rewrite_nxt = 1'b0;
            else if (wr0_seen_r)
                rewrite_nxt = 1'b1;
            if (rewrite_r)
                frst_nxt = pwdata[B_FRST];
            else if (!pwdata[B_FRST])
                frst_nxt = 1'b0;
        end
        else if (wr_acc)
            wr0_seen_nxt = 1'b0;
        if (wr_acc && paddr == OFS_ADDR)
            addr_nxt = pwdata[ADDR_W:0];
        if (wr_acc && paddr == OFS_DATA)
            data_nxt = pwdata[DATA_W-1:0];
    end

    // operation sequencer; error flags: set beats clear
    always_comb
    begin
        state_nxt = state_r;
        op_nxt    = op_r;
        perr_nxt  = perr_r;
        eerr_nxt  = eerr_r;
        rdat_nxt  = rdat_r;
        if (cmd_go && cmd_code == CMD_CLR_STATUS)
        begin
            perr_nxt = 1'b0;
            eerr_nxt = 1'b0;
        end
        unique case (state_r)
            FRM_IDLE:
            begin
                if (cmd_go)
                begin
                    op_nxt.boot_area = cmd_boot;
                    op_nxt.addr      = cmd_addr;
                    op_nxt.data      = cmd_data;
                    unique case (cmd_code)
                        CMD_RD_ARRAY:
                        begin
                            op_nxt.valid = 1'b1;
                            op_nxt.kind  = FRM_OP_READ;
                            state_nxt    = FRM_BUSY;
                        end
                        CMD_PROGRAM:
                        begin
                            if (allowed)
                            begin
                                op_nxt.valid = 1'b1;
                                op_nxt.kind  = FRM_OP_PROGRAM;
                                state_nxt    = FRM_BUSY;
                            end
                            else
                                perr_nxt = 1'b1;
                        end
                        CMD_BLK_ERASE:
                        begin
                            // block named by its top address; boot area is one block
                            if (allowed && (cmd_addr & (cmd_boot ? BOOT_MASK : USER_MASK))
                                == (cmd_boot ? BOOT_MASK : USER_MASK))
                            begin
                                op_nxt.valid = 1'b1;
                                op_nxt.kind  = FRM_OP_ERASE;
                                state_nxt    = FRM_BUSY;
                            end
                            else
                                eerr_nxt = 1'b1;
                        end
                        default: ;
                    endcase
                end
            end
            FRM_BUSY:
            begin
                if (resp.done)
                begin
                    op_nxt.valid = 1'b0;
                    state_nxt    = FRM_IDLE;
                    if (op_r.kind == FRM_OP_READ)
                        rdat_nxt = resp.rdata;
                    if (resp.fail && op_r.kind == FRM_OP_PROGRAM)
                        perr_nxt = 1'b1;
                    if (resp.fail && op_r.kind == FRM_OP_ERASE)
                        eerr_nxt = 1'b1;
                end
            end
        endcase
        if (frst_r)
        begin
            // flash reset aborts whatever is in flight
            op_nxt.valid = 1'b0;
            state_nxt    = FRM_IDLE;
        end
    end

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r    <= FRM_IDLE;
            start_r    <= FRM_START_NORMAL;
            sampled_r  <= 1'b0;
            rewrite_r  <= 1'b0;
            wr0_seen_r <= 1'b0;
            frst_r     <= 1'b0;
            perr_r     <= 1'b0;
            eerr_r     <= 1'b0;
            addr_r     <= '0;
            data_r     <= '0;
            rdat_r     <= '0;
            op_r       <= '0;
            prdata_r   <= '0;
            pslverr_r  <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            start_r    <= start_nxt;
            sampled_r  <= sampled_nxt;
            rewrite_r  <= rewrite_nxt;
            wr0_seen_r <= wr0_seen_nxt;
            frst_r     <= frst_nxt;
            perr_r     <= perr_nxt;
            eerr_r     <= eerr_nxt;
            addr_r     <= addr_nxt;
            data_r     <= data_nxt;
            rdat_r     <= rdat_nxt;
            op_r       <= op_nxt;
            prdata_r   <= prdata_nxt;
            pslverr_r  <= pslverr_nxt;
        end
    end

    a_ready_tracks_op: assert property (@(posedge clock) disable iff (!rst_b)
        ctrl_view[B_READY] == !op_r.valid)
        else $error("ready flag disagrees with operation in flight");

    a_rewrite_needs_zero: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(rewrite_r) |-> $past(wr0_seen_r) && $past(wr_ctrl))
        else $error("rewrite bit set without preceding zero write");

    a_rewrite_zero_clears: assert property (@(posedge clock) disable iff (!rst_b)
        wr_ctrl && !pwdata[B_REWRITE] |=> !rewrite_r)
        else $error("zero write did not clear rewrite bit");

    a_boot_write_guard: assert property (@(posedge clock) disable iff (!rst_b)
        op_r.valid && op_r.kind != FRM_OP_READ && op_r.boot_area |-> par_mode)
        else $error("boot area modified outside parallel mode");

    a_cpu_no_read: assert property (@(posedge clock) disable iff (!rst_b)
        rewrite_r |-> !cpu_flash_read_en && access_mode == FRM_ACC_CPU)
        else $error("cpu flash read open in rewrite mode");

    a_start_kept: assert property (@(posedge clock) disable iff (!rst_b)
        sampled_r |=> $stable(start_r))
        else $error("start-up mode changed after sampling");

    a_refused_program: assert property (@(posedge clock) disable iff (!rst_b)
        cmd_go && cmd_code == CMD_PROGRAM && !allowed |=> perr_r && !op_r.valid)
        else $error("refused program did not flag error");

    a_erase_top_addr: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(op_r.valid) && op_r.kind == FRM_OP_ERASE && !op_r.boot_area
        |-> (op_r.addr & USER_MASK) == USER_MASK)
        else $error("erase started on a non top address");

    a_flash_reset_hold: assert property (@(posedge clock) disable iff (!rst_b)
        frst_r ##1 frst_r |-> !op_r.valid [*2])
        else $error("operation alive during flash reset");

    a_normal_start: assert property (@(posedge clock) disable iff (!rst_b)
        !sampled_r && !processor_mode_pin |=> start_r == FRM_START_NORMAL && !fetch_from_boot)
        else $error("low processor mode pin did not give normal start");

endmodule // frm_ctrl

/* src/frm_pkg.sv */
// shared constants and carriers for the flash rewrite mode control block
package frm_pkg;
    localparam int unsigned      ADDR_W         = 16;
    localparam int unsigned      DATA_W         = 8;
    // register byte offsets on the apb side
    localparam logic [7:0]       OFS_CTRL       = 8'h00;
    localparam logic [7:0]       OFS_ADDR       = 8'h04;
    localparam logic [7:0]       OFS_DATA       = 8'h08;
    localparam logic [7:0]       OFS_CMD        = 8'h0c;
    localparam logic [7:0]       OFS_RDAT       = 8'h10;
    // control register fields, then B_AREA, the area bit of the address register
    localparam int unsigned      B_READY        = 0;
    localparam int unsigned      B_REWRITE      = 1;
    localparam int unsigned      B_FRST         = 3;
    localparam int unsigned      B_PERR         = 6;
    localparam int unsigned      B_EERR         = 7;
    localparam int unsigned      B_START_LO     = 8;
    localparam int unsigned      B_AREA         = 16;
    // boot area: one undivided 4 kbyte erase region
    localparam int unsigned      BOOT_BYTES     = 4096;
    localparam int unsigned      BOOT_BLK_BITS  = $clog2(BOOT_BYTES);
    localparam logic [15:0]      BOOT_VECTOR    = 16'hfffc;
    // software command codes, five kinds
    localparam logic [7:0]       CMD_RD_ARRAY   = 8'h01;
    localparam logic [7:0]       CMD_RD_STATUS  = 8'h02;
    localparam logic [7:0]       CMD_CLR_STATUS = 8'h03;
    localparam logic [7:0]       CMD_PROGRAM    = 8'h04;
    localparam logic [7:0]       CMD_BLK_ERASE  = 8'h05;

    typedef enum logic [1:0] {FRM_START_NORMAL, FRM_START_BOOT, FRM_START_PARALLEL} frm_start_e;
    typedef enum logic [1:0] {FRM_ACC_NONE, FRM_ACC_PARALLEL, FRM_ACC_SERIAL, FRM_ACC_CPU} frm_acc_e;
    typedef enum logic [1:0] {FRM_OP_READ, FRM_OP_PROGRAM, FRM_OP_ERASE} frm_op_e;

    typedef struct packed {
        logic                    valid;
        frm_op_e                 kind;
        logic                    boot_area;
        logic [ADDR_W-1:0]       addr;
        logic [DATA_W-1:0]       data;
    } frm_op_s;

    typedef struct packed {
        logic                    req;
        logic [7:0]              cmd;
        logic                    boot_area;
        logic [ADDR_W-1:0]       addr;
        logic [DATA_W-1:0]       data;
    } frm_prog_s;

    typedef struct packed {
        logic                    done;
        logic                    fail;
        logic [DATA_W-1:0]       rdata;
    } frm_resp_s;
endpackage

/* verif/frm_flash_model.sv */
// flash array stand-in that answers the control block's operations
`timescale 1ns/1ps
module frm_flash_model (
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire frm_pkg::frm_op_s  op,
    input  wire logic              slow,
    input  wire logic              fail_nxt,
    output frm_pkg::frm_resp_s     resp
);
    import frm_pkg::*;
    logic [7:0] umem [0:65535];
    logic [7:0] bmem [0:4095];
    logic [7:0] last;
    logic       done_r;
    logic       fail_r;
    logic       ers;
    int         cnt;

    // erased cells read all ones
    initial
    begin
        foreach (umem[i]) umem[i] = 8'hff;
        foreach (bmem[i]) bmem[i] = 8'hff;
    end

    assign ers = !fail_nxt && op.kind == FRM_OP_ERASE;
    // outside the done pulse the lines show inverted data, never a stale copy
    assign resp = {done_r, done_r ? fail_r : ~fail_r, done_r ? last : ~last};

    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            done_r <= 1'b0;
            fail_r <= 1'b0;
            last <= 8'h00;
            cnt <= 0;
        end
        else if (op.valid && !done_r && cnt >= (slow ? 8 : 1))
        begin
            done_r <= 1'b1;
            fail_r <= fail_nxt;
            cnt <= 0;
            last <= op.boot_area ? bmem[op.addr[11:0]] : umem[op.addr];
            if (!fail_nxt && op.kind == FRM_OP_PROGRAM && op.boot_area)
                bmem[op.addr[11:0]] <= op.data;
            if (!fail_nxt && op.kind == FRM_OP_PROGRAM && !op.boot_area)
                umem[op.addr] <= op.data;
            for (int i = 0; i < 8192; i++)
            begin
                if (ers && op.boot_area && i < 4096)
                    bmem[i] <= 8'hff;
                if (ers && !op.boot_area)
                    umem[{op.addr[15:13], i[12:0]}] <= 8'hff;
            end
        end
        else
        begin
            done_r <= 1'b0;
            cnt <= (op.valid && !done_r) ? cnt + 1 : 0;
        end
    end
endmodule // frm_flash_model

/* verif/flash_rewrite_mode_control_bench.sv */
// self-checking bench for the flash rewrite mode control
`timescale 1ns/1ps
module flash_rewrite_mode_control_bench;
    import frm_pkg::*;
    logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, qerr;
    logic        readout_protect, prog_busy, prog_read_en, flash_ctl_rst;
    logic        cpu_flash_read_en, fetch_from_boot, slow, fail_nxt;
    logic [4:0]  straps;
    logic [7:0]  paddr, d;
    logic [15:0] reset_vector_addr, a;
    logic [31:0] pwdata, prdata, q, seed;
    frm_prog_s   prog;
    frm_resp_s   resp;
    frm_op_s     op;
    frm_start_e  start_mode;
    frm_acc_e    access_mode;
    int          n_mismatch, samples_checked;

    frm_ctrl uut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .processor_mode_pin(straps[4]), .boot_select_pin(straps[3]), .chip_enable_pin(straps[2]),
        .serial_clock_pin(straps[1]), .serial_transmit_pin(straps[0]), .readout_protect(readout_protect),
        .prog(prog), .prog_busy(prog_busy), .prog_read_en(prog_read_en), .resp(resp), .op(op),
        .flash_ctl_rst(flash_ctl_rst), .cpu_flash_read_en(cpu_flash_read_en),
        .fetch_from_boot(fetch_from_boot), .reset_vector_addr(reset_vector_addr),
        .start_mode(start_mode), .access_mode(access_mode));
    frm_flash_model flash (.clock(clock), .rst_b(rst_b), .op(op), .slow(slow), .fail_nxt(fail_nxt),
        .resp(resp));

    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic end_of_test();
        if (n_mismatch == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    function automatic logic [31:0] cx(logic rdy, logic rw, logic fr, logic pe, logic ee, logic [1:0] sm);
        return {22'h0, sm, ee, pe, 2'b00, fr, 1'b0, rw, rdy};
    endfunction

    // no wait is assumed: pready is polled, only the watchdog bounds it
    task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do
        begin
            @(posedge clock);
        end
        while (pready !== 1'b1);
        q = prdata;
        qerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // flops launched at the access edge are looked at once settled
        @(negedge clock);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [31:0] e, input string m);
        apb(1'b0, ad, 32'h0);
        chk(q & (ad == OFS_CTRL ? 32'h3cb : 32'hff), e, m);
    endtask

    task automatic cmd(input logic [7:0] c, input logic b, input logic [15:0] ad, input logic [7:0] dd);
        apb(1'b1, OFS_ADDR, {15'h0, b, ad});
        apb(1'b1, OFS_DATA, {24'h0, dd});
        apb(1'b1, OFS_CMD, {24'h0, c});
    endtask

    task automatic pcmd(input logic [7:0] c, input logic b, input logic [15:0] ad, input logic [7:0] dd);
        @(posedge clock);
        prog <= {1'b1, c, b, ad, dd};
        @(posedge clock);
        prog <= {1'b0, ~prog[32:0]};
    endtask

    task automatic wait_op(input frm_op_e k, input logic b, input logic [15:0] ad, input logic [7:0] dd);
        int n;
        n = 0;
        while (op.valid !== 1'b1 && n < 20)
        begin
            @(negedge clock);
            n++;
        end
        chk(op.valid, 1'b1, "op start");
        chk({op.kind, op.boot_area, op.addr, op.data}, {k, b, ad, dd}, "op fields");
        n = 0;
        while (op.valid !== 1'b0 && n < 50)
        begin
            @(negedge clock);
            n++;
        end
        chk(op.valid, 1'b0, "op end");
    endtask

    task automatic no_op(input string m);
        logic s;
        s = 1'b0;
        repeat (4)
        begin
            @(negedge clock);
            s |= op.valid;
        end
        chk(s, 1'b0, m);
    endtask

    // straps held across reset and the first edge after it
    task automatic boot_with(input logic [4:0] s);
        @(posedge clock);
        rst_b <= 1'b0;
        straps <= s;
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask

    initial
    begin
        #(40 * 20000);
        n_mismatch++;
        end_of_test();
    end

    initial
    begin
        seed = 32'h6037;
        n_mismatch = 0;
        samples_checked = 0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {rst_b, straps, readout_protect, slow, fail_nxt} = '0;
        prog = '0;
        boot_with(5'b00000);
        chk({start_mode, access_mode, fetch_from_boot, cpu_flash_read_en}, {FRM_START_NORMAL, FRM_ACC_NONE, 2'b01}, "normal");
        chk(reset_vector_addr, 16'hfffc, "vector");
        rd(OFS_CTRL, cx(1, 0, 0, 0, 0, 2'd0), "idle");
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_ADDR, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h2);
        rd(OFS_CTRL, cx(1, 0, 0, 0, 0, 2'd0), "cancelled set");
        cmd(CMD_PROGRAM, 1'b0, 16'h0100, 8'h5a);
        no_op("command outside rewrite");
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h2);
        rd(OFS_CTRL, cx(1, 1, 0, 0, 0, 2'd0), "rewrite set");
        chk({access_mode, cpu_flash_read_en}, {FRM_ACC_CPU, 1'b0}, "cpu mode");
        repeat (4)
        begin
            a = 16'($random(seed));
            d = 8'($random(seed));
            slow = 1'($random(seed));
            cmd(CMD_PROGRAM, 1'b0, a, d);
            wait_op(FRM_OP_PROGRAM, 1'b0, a, d);
            cmd(CMD_RD_ARRAY, 1'b0, a, d);
            wait_op(FRM_OP_READ, 1'b0, a, d);
            rd(OFS_RDAT, {24'h0, d}, "read back");
        end
        slow = 1'b1;
        cmd(CMD_PROGRAM, 1'b0, 16'h0200, 8'h00);
        rd(OFS_CTRL, cx(0, 1, 0, 0, 0, 2'd0), "busy");
        chk(prog_busy, 1'b1, "busy flag");
        wait_op(FRM_OP_PROGRAM, 1'b0, 16'h0200, 8'h00);
        fail_nxt = 1'b1;
        cmd(CMD_PROGRAM, 1'b0, 16'h0300, 8'h11);
        wait_op(FRM_OP_PROGRAM, 1'b0, 16'h0300, 8'h11);
        cmd(CMD_BLK_ERASE, 1'b0, 16'h3fff, 8'h11);
        wait_op(FRM_OP_ERASE, 1'b0, 16'h3fff, 8'h11);
        fail_nxt = 1'b0;
        rd(OFS_CTRL, cx(1, 1, 0, 1, 1, 2'd0), "errors");
        cmd(CMD_CLR_STATUS, 1'b0, 16'h0, 8'h0);
        no_op("clear");
        rd(OFS_CTRL, cx(1, 1, 0, 0, 0, 2'd0), "cleared");
        cmd(CMD_PROGRAM, 1'b1, 16'hf000, 8'h33);
        no_op("boot program");
        cmd(CMD_BLK_ERASE, 1'b1, 16'hffff, 8'h33);
        no_op("boot erase");
        cmd(CMD_BLK_ERASE, 1'b0, 16'h1ffe, 8'h0);
        no_op("erase not top");
        rd(OFS_CTRL, cx(1, 1, 0, 1, 1, 2'd0), "refusals");
        cmd(CMD_CLR_STATUS, 1'b0, 16'h0, 8'h0);
        cmd(CMD_RD_STATUS, 1'b0, 16'h0, 8'h0);
        no_op("status");
        rd(OFS_CTRL, cx(1, 1, 0, 0, 0, 2'd0), "status kept clear");
        cmd(CMD_BLK_ERASE, 1'b0, 16'h1fff, 8'h0);
        wait_op(FRM_OP_ERASE, 1'b0, 16'h1fff, 8'h0);
        cmd(CMD_RD_ARRAY, 1'b0, 16'h0200, 8'h0);
        wait_op(FRM_OP_READ, 1'b0, 16'h0200, 8'h0);
        rd(OFS_RDAT, 32'hff, "erased");
        apb(1'b1, OFS_CTRL, 32'ha);
        chk(flash_ctl_rst, 1'b1, "flash reset");
        cmd(CMD_PROGRAM, 1'b0, 16'h0400, 8'h44);
        no_op("held in reset");
        apb(1'b1, OFS_CTRL, 32'h2);
        chk(flash_ctl_rst, 1'b0, "reset off");
        apb(1'b0, 8'h20, 32'h0);
        chk({qerr, q[30:0]}, 32'h80000000, "unmapped");
        apb(1'b1, OFS_CTRL, 32'h0);
        chk({access_mode, cpu_flash_read_en}, {FRM_ACC_NONE, 1'b1}, "rewrite off");
        boot_with(5'b10101);
        chk({start_mode, fetch_from_boot, access_mode, prog_read_en}, {FRM_START_BOOT, 1'b1, FRM_ACC_SERIAL, 1'b1}, "boot");
        @(posedge clock);
        straps <= 5'h0;
        readout_protect <= 1'b1;
        @(negedge clock);
        chk({start_mode, prog_read_en}, {FRM_START_BOOT, 1'b0}, "kept");
        apb(1'b1, OFS_CTRL, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h2);
        cmd(CMD_PROGRAM, 1'b0, 16'h0500, 8'h55);
        wait_op(FRM_OP_PROGRAM, 1'b0, 16'h0500, 8'h55);
        boot_with(5'b11101);
        chk({start_mode, access_mode, prog_read_en}, {FRM_START_PARALLEL, FRM_ACC_PARALLEL, 1'b0}, "parallel");
        @(posedge clock);
        readout_protect <= 1'b0;
        @(negedge clock);
        chk(prog_read_en, 1'b1, "unprotected");
        pcmd(CMD_PROGRAM, 1'b1, 16'hf123, 8'h66);
        wait_op(FRM_OP_PROGRAM, 1'b1, 16'hf123, 8'h66);
        pcmd(CMD_BLK_ERASE, 1'b1, 16'hfffe, 8'h0);
        no_op("boot part erase");
        pcmd(CMD_BLK_ERASE, 1'b1, 16'hffff, 8'h0);
        wait_op(FRM_OP_ERASE, 1'b1, 16'hffff, 8'h0);
        end_of_test();
    end
endmodule // flash_rewrite_mode_control_bench
